// file: hw/lsd_consts.svh
// constants for the led sink shift and latch block
// assumes inclusion by the top module, the host model and the testbench
`ifndef LSD_CONSTS_SVH
`define LSD_CONSTS_SVH

// channel count and sequence length
`define LSD_CHANNELS 16
`define LSD_SEQ_LEN 5
// enable pin pattern for both sequences, oldest bit high
`define LSD_SEQ_OE 5'h17
// latch pin pattern for entry and for resume
`define LSD_SEQ_LE_ENTER 5'h02
`define LSD_SEQ_LE_RESUME 5'h00
// idle edges before power saving
`define LSD_IDLE_EDGES 5'h10
// clock rate and least fault evaluation time
`define LSD_CLK_MHZ 25
`define LSD_EVAL_NS 1000
`define LSD_EVAL_CYC ((`LSD_EVAL_NS * `LSD_CLK_MHZ + 999) / 1000)
// fifo shape in the edge path
`define LSD_FIFO_WIDTH 3
`define LSD_FIFO_DEPTH 4

`endif

// file: hw/lsd_pkg.sv
// types for the led sink shift and latch block
// assumes the consts header carries all numbers
package lsd_pkg;
  // operating mode, one-hot
  typedef enum logic [1:0] {
    LSD_NORMAL = 2'b01,
    LSD_DETECT = 2'b10
  } lsd_mode_t;
endpackage : lsd_pkg

// file: hw/lsd_fifo.sv
// small fifo with valid and ready on both sides
// assumes one clock and an active high async reset
`timescale 1ns/1ps
module lsd_fifo #(
  parameter int WIDTH = 3,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  // storage and pointers
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  // honest full and empty
  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // next pointer values
  always_comb begin
    wr_d = push ? ((wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1) : wr_q;
    rd_d = pop ? ((rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1) : rd_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  // register pointers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // storage write, no reset needed on data
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
endmodule : lsd_fifo

// file: hw/lsd_top.sv
// led sink driver control: shift, latch, enable, detection, power save
// assumes host pins are asynchronous to ref_clk and change slowly vs it
//
// Contract
// - latch and enable act on level
// - latch low holds stored data
// - latch high makes storage transparent
// - enable low: channels follow latched bits
// - enable high forces all channels off
// - latched one on, zero off
// - enable pin is active low
// - recognise five-clock detection entry pattern
// - sample data from sixth edge on
// - all ones latched means ready to test
// - enable low in detection evaluates faults
// - enable rise loads results into shifter
// - results use normal frame and order
// - recognise five-clock resume pattern
// - low current flags open or ground short
// - high voltage flags led or supply short
// - low power when latch holds nothing
// - leave power save on first active bit; code leaves on the first edge that changes the shift register contents
// - power save after sixteen unchanged edges
`timescale 1ns/1ps
`include "lsd_consts.svh"
module lsd_top (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // host pins
  input wire logic serial_clk_pin,
  input wire logic serial_in_pin,
  input wire logic latch_mode_pin,
  input wire logic enable_mode_pin,
  output logic serial_out_pin,
  // analog fault comparators per channel
  input wire logic [`LSD_CHANNELS-1:0] current_low_pin,
  input wire logic [`LSD_CHANNELS-1:0] voltage_high_pin,
  // outputs to the sink stage
  output logic [`LSD_CHANNELS-1:0] sink_channel,
  output logic power_save,
  output logic detect_mode,
  // edge fifo back-pressure, low means the fifo is full and a new edge would be dropped
  output logic edge_ready
);
  localparam int N = `LSD_CHANNELS;
  localparam int PW = 4 + 2 * N;
  localparam logic [7:0] EVAL_CYC = 8'(`LSD_EVAL_CYC);

  // synchroniser stages and filtered levels
  logic [PW-1:0] pins, s1_q, s2_q, s3_q, flt_q, flt_d;
  // filtered pin views
  logic clk_f, sdi_f, le_f, oe_f;
  logic [N-1:0] cur_low_f, volt_high_f;
  // serial clock edge detect
  logic clk_prev_q;
  logic clk_rise;
  // fifo drain side
  logic ev_valid, ev_ready;
  logic [2:0] ev_data;
  logic ev_sdi, ev_le, ev_oe, ev_pop;
  // shift register, latch and sink state
  logic [N-1:0] shift_q, shift_d, latch_q, latch_d, sink_q, sink_d;
  // mode sequence history, newest in bit 0
  logic [`LSD_SEQ_LEN-1:0] hist_oe_q, hist_oe_d, hist_le_q, hist_le_d;
  lsd_pkg::lsd_mode_t mode_q, mode_d;
  // detection evaluation state
  logic [7:0] eval_q, eval_d;
  logic [N-1:0] result_q, result_d;
  logic eval_done_q, eval_done_d, oe_prev_q, load_q, load_d;
  // power save state
  logic [4:0] idle_q, idle_d;
  logic psave_q, psave_d;

  // fault flags for every channel from both comparators
  function automatic logic [N-1:0] fault_of(input logic [N-1:0] cur_low,
                                            input logic [N-1:0] volt_high);
    fault_of = cur_low | volt_high;
  endfunction : fault_of

  // match of the five-clock history against a pattern
  function automatic logic seq_hit(input logic [`LSD_SEQ_LEN-1:0] oe_h,
                                   input logic [`LSD_SEQ_LEN-1:0] le_h,
                                   input logic [`LSD_SEQ_LEN-1:0] le_p);
    seq_hit = (oe_h == `LSD_SEQ_OE) && (le_h == le_p);
  endfunction : seq_hit

  // gather every outside pin into one vector
  assign pins = {voltage_high_pin, current_low_pin, enable_mode_pin,
                 latch_mode_pin, serial_in_pin, serial_clk_pin};

  // a bit moves only once the second and third stages agree
  always_comb begin
    flt_d = (s2_q & s3_q) | (flt_q & (s2_q | s3_q));
  end

  // three flip-flop synchronisers and filtered levels
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      flt_q <= '0;
      clk_prev_q <= 1'b0;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
      flt_q <= flt_d;
      clk_prev_q <= flt_q[0];
    end
  end

  // filtered views
  assign clk_f = flt_q[0];
  assign sdi_f = flt_q[1];
  assign le_f = flt_q[2];
  assign oe_f = flt_q[3];
  assign cur_low_f = flt_q[4 +: N];
  assign volt_high_f = flt_q[4 + N +: N];
  assign clk_rise = clk_f & ~clk_prev_q;

  // serial clock edges wait here while a result load stalls the shifter
  lsd_fifo #(
    .WIDTH(`LSD_FIFO_WIDTH),
    .DEPTH(`LSD_FIFO_DEPTH)
  ) u_edge_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_valid(clk_rise),
    .in_ready(edge_ready),
    .in_data({sdi_f, le_f, oe_f}),
    .out_valid(ev_valid),
    .out_ready(ev_ready),
    .out_data(ev_data)
  );

  // drain stalls during the result load cycle
  assign ev_ready = ~load_q;
  assign ev_pop = ev_valid & ev_ready;
  assign {ev_sdi, ev_le, ev_oe} = ev_data;

  // shift register, history and mode next values
  always_comb begin
    shift_d = shift_q;
    hist_oe_d = hist_oe_q;
    hist_le_d = hist_le_q;
    mode_d = mode_q;
    if (load_q) begin
      shift_d = result_q;
    end else if (ev_pop) begin
      shift_d = {shift_q[N-2:0], ev_sdi};
      hist_oe_d = {hist_oe_q[`LSD_SEQ_LEN-2:0], ev_oe};
      hist_le_d = {hist_le_q[`LSD_SEQ_LEN-2:0], ev_le};
      case (mode_q)
        lsd_pkg::LSD_NORMAL: begin
          if (seq_hit(hist_oe_d, hist_le_d, `LSD_SEQ_LE_ENTER)) begin
            mode_d = lsd_pkg::LSD_DETECT;
            hist_oe_d = '0;
            hist_le_d = '0;
          end
        end
        lsd_pkg::LSD_DETECT: begin
          if (seq_hit(hist_oe_d, hist_le_d, `LSD_SEQ_LE_RESUME)) begin
            mode_d = lsd_pkg::LSD_NORMAL;
            hist_oe_d = '0;
            hist_le_d = '0;
          end
        end
        // stray code falls back to normal
        default: begin
          mode_d = lsd_pkg::LSD_NORMAL;
        end
      endcase
    end
  end

  // register shift register, history and mode
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      shift_q <= '0;
      hist_oe_q <= '0;
      hist_le_q <= '0;
      mode_q <= lsd_pkg::LSD_NORMAL;
    end else begin
      shift_q <= shift_d;
      hist_oe_q <= hist_oe_d;
      hist_le_q <= hist_le_d;
      mode_q <= mode_d;
    end
  end

  // latch and sink next values, acting on levels every cycle
  always_comb begin
    latch_d = le_f ? shift_q : latch_q;
    sink_d = oe_f ? '0 : latch_q;
  end

  // register latch and sinks
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      latch_q <= '0;
      sink_q <= '0;
    end else begin
      latch_q <= latch_d;
      sink_q <= sink_d;
    end
  end

  // detection evaluation next values
  always_comb begin
    eval_d = eval_q;
    eval_done_d = eval_done_q;
    result_d = result_q;
    load_d = 1'b0;
    if (mode_q != lsd_pkg::LSD_DETECT) begin
      // leaving detection clears any partial evaluation
      eval_d = '0;
      eval_done_d = 1'b0;
    end else if (!oe_f && (&latch_q)) begin
      if (eval_q < EVAL_CYC) begin
        eval_d = eval_q + 8'h01;
      end else begin
        result_d = fault_of(cur_low_f, volt_high_f);
        eval_done_d = 1'b1;
      end
    end else if (oe_f && !oe_prev_q && eval_done_q) begin
      load_d = 1'b1;
      eval_d = '0;
      eval_done_d = 1'b0;
    end else if (oe_f) begin
      // enable high before the settle time restarts the count
      eval_d = '0;
    end
  end

  // register detection evaluation
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      eval_q <= '0;
      eval_done_q <= 1'b0;
      result_q <= '0;
      load_q <= 1'b0;
      oe_prev_q <= 1'b1;
    end else begin
      eval_q <= eval_d;
      eval_done_q <= eval_done_d;
      result_q <= result_d;
      load_q <= load_d;
      oe_prev_q <= oe_f;
    end
  end

  // power save next values
  always_comb begin
    idle_d = idle_q;
    if (ev_pop && !load_q) begin
      if ({shift_q[N-2:0], ev_sdi} == shift_q) begin
        idle_d = (idle_q < `LSD_IDLE_EDGES) ? idle_q + 5'h01 : idle_q;
      end else begin
        idle_d = '0;
      end
    end
    psave_d = (latch_q == '0) && (idle_q >= `LSD_IDLE_EDGES);
  end

  // register power save
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      idle_q <= '0;
      psave_q <= 1'b0;
    end else begin
      idle_q <= idle_d;
      psave_q <= psave_d;
    end
  end

  // outputs, three straight from flip-flops, detect_mode decoded from mode_q
  assign serial_out_pin = shift_q[N-1];
  assign sink_channel = sink_q;
  assign power_save = psave_q;
  assign detect_mode = (mode_q == lsd_pkg::LSD_DETECT);
endmodule : lsd_top

// file: verification/lsd_top_monitor.sv
// checker for the led sink control block, bound to its top
// assumes host pins move slowly against ref_clk
`timescale 1ns/1ps
module lsd_top_monitor (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // host pins
  input wire logic serial_clk_pin,
  input wire logic latch_mode_pin,
  input wire logic enable_mode_pin,
  input wire logic serial_out_pin,
  // device outputs
  input wire logic [15:0] sink_channel,
  input wire logic power_save,
  input wire logic detect_mode,
  input wire logic edge_ready
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [4:0] quiet_q; // cycles since clock or enable pin moved
  logic [4:0] quiet_d;
  logic [1:0] pins_q; // last pin levels
  // restart on a pin move, saturate at 31
  always_comb begin
    quiet_d = quiet_q;
    if (pins_q != {serial_clk_pin, enable_mode_pin}) quiet_d = 5'h00;
    else if (quiet_q != 5'h1f) quiet_d = quiet_q + 5'h01;
  end
  // register the quiet count
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      quiet_q <= 5'h00;
      pins_q <= 2'h0;
    end else begin
      quiet_q <= quiet_d;
      pins_q <= {serial_clk_pin, enable_mode_pin};
    end
  end
  sequence s_off_held;
    enable_mode_pin [*8];
  endsequence
  sequence s_hold_on;
    (!latch_mode_pin && !enable_mode_pin) [*8];
  endsequence
  a_sink_forced_off: assert property (s_off_held |-> ##1 sink_channel == 16'h0000)
    else $error("sinks on while enable held off");
  a_latch_holds: assert property (s_hold_on |=> $stable(sink_channel))
    else $error("sinks moved while latch closed");
  a_sink_needs_enable: assert property ($rose(|sink_channel) |-> $past(!enable_mode_pin, 3))
    else $error("sinks rose without enable");
  a_lit_not_saving: assert property ((|sink_channel) |=> !power_save)
    else $error("power save with active data");
  a_reset_clears: assert property (disable iff (1'b0) rst [*2] |-> sink_channel == 16'h0000
    && !power_save && !detect_mode && edge_ready && !serial_out_pin)
    else $error("outputs not cleared in reset");
  a_mode_quiet: assert property (quiet_q == 5'h1f |-> $stable(detect_mode))
    else $error("mode changed without serial edges");
  a_out_quiet: assert property (quiet_q == 5'h1f |-> $stable(serial_out_pin))
    else $error("serial out moved without edge");
  a_ready_normal: assert property (!detect_mode |-> edge_ready)
    else $error("edge dropped in normal mode");
endmodule : lsd_top_monitor

// file: verification/lsd_host.sv
// host model driving serial, latch and enable pins
// assumes ref_clk runs free; pins change 1 ns after its edge
`timescale 1ns/1ps
`include "lsd_consts.svh"
module lsd_host (
  // clock
  input wire logic ref_clk,
  // pins to the device
  output logic serial_clk_pin,
  output logic serial_in_pin,
  output logic latch_mode_pin,
  output logic enable_mode_pin,
  // pin from the device
  input wire logic serial_out_pin
);
  // idle: clock low, outputs disabled
  initial begin
    serial_clk_pin = 1'b0;
    serial_in_pin = 1'b0;
    latch_mode_pin = 1'b0;
    enable_mode_pin = 1'b1;
  end
  // wait n edges, then step past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  // one serial edge, read out before the rise
  task automatic step(input logic d, input logic le, input logic oe, output logic q);
    serial_in_pin = d;
    latch_mode_pin = le;
    enable_mode_pin = oe;
    tick(8);
    q = serial_out_pin;
    serial_clk_pin = 1'b1;
    tick(8);
    serial_clk_pin = 1'b0;
    serial_in_pin = ~d; // data no longer held
  endtask : step
  task automatic frame(input logic [15:0] d, input logic oe, output logic [15:0] got);
    for (int i = 15; i >= 0; i--) step(d[i], 1'b0, oe, got[i]);
  endtask : frame
  task automatic mode_seq(input logic [4:0] le_pat);
    logic [4:0] oe_pat = `LSD_SEQ_OE;
    logic q;
    for (int i = 4; i >= 0; i--) step(1'b1, le_pat[i], oe_pat[i], q);
  endtask : mode_seq
  task automatic strobe();
    latch_mode_pin = 1'b1;
    tick(10);
    latch_mode_pin = 1'b0;
    tick(10);
  endtask : strobe
  task automatic enable_for(input logic oe, input int n);
    enable_mode_pin = oe;
    tick(n);
  endtask : enable_for
endmodule : lsd_host

// file: verification/testbench.sv
// top bench: host model, device, queued checks
// assumes a 25 MHz ref_clk and pins filtered inside the device
`timescale 1ns/1ps
`include "lsd_consts.svh"
module testbench;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic serial_clk_pin, serial_in_pin, latch_mode_pin, enable_mode_pin, serial_out_pin;
  logic [15:0] current_low_pin = 16'h0000;
  logic [15:0] voltage_high_pin = 16'h0000;
  logic [15:0] sink_channel;
  logic power_save, detect_mode, edge_ready;
  int n_fail = 0;
  int checks_done = 0;
  logic [15:0] notes_q[$]; // expected results, oldest first
  logic [15:0] obs; // result handed to the watcher
  event look;
  always #20 ref_clk = ~ref_clk;
  lsd_top i_lsd_top (.ref_clk, .rst, .serial_clk_pin, .serial_in_pin, .latch_mode_pin,
    .enable_mode_pin, .serial_out_pin, .current_low_pin, .voltage_high_pin, .sink_channel,
    .power_save, .detect_mode, .edge_ready);
  lsd_host i_lsd_host (.ref_clk, .serial_clk_pin, .serial_in_pin, .latch_mode_pin,
    .enable_mode_pin, .serial_out_pin);
  // verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop
  // queue a note, hand the result over
  task automatic note(input logic [15:0] exp, input logic [15:0] got);
    notes_q.push_back(exp);
    obs = got;
    -> look;
    // resume one step past the next edge, so every pin moves at the same offset
    @(posedge ref_clk);
    #1;
  endtask : note
  // bounded wait on detect_mode or power_save
  task automatic wait_flag(input bit which, input logic want);
    for (int k = 0; k < 60; k++) begin
      if ((which ? power_save : detect_mode) === want) return;
      // look once the edge's updates have settled
      @(posedge ref_clk);
      #1;
    end
    n_fail++;
    $display("unexpected at %0t: got %h exp %h", $time, which ? power_save : detect_mode, want);
    report_and_stop();
  endtask : wait_flag
  // watcher: oldest note against each result
  initial begin
    logic [15:0] e;
    forever begin
      @(look);
      e = notes_q.pop_front();
      checks_done++;
      if (obs !== e) begin
        n_fail++;
        $display("unexpected at %0t: got %h exp %h", $time, obs, e);
      end
    end
  end
  // hang guard
  initial begin
    #2000000;
    n_fail++;
    $display("unexpected at %0t: got %h exp %h", $time, checks_done, n_fail);
    report_and_stop();
  end
  // main sequence
  initial begin
    logic [15:0] d;
    logic [15:0] got;
    d = 16'($urandom(12));
    repeat (2) @(posedge ref_clk);
    #1 rst = 1'b0;
    note(16'h0000, sink_channel);
    d = 16'($urandom);
    i_lsd_host.enable_for(1'b0, 10);
    i_lsd_host.frame(d, 1'b0, got);
    note(16'h0000, sink_channel);
    i_lsd_host.strobe();
    note(d, sink_channel);
    i_lsd_host.enable_for(1'b1, 10);
    note(16'h0000, sink_channel);
    i_lsd_host.enable_for(1'b0, 10);
    i_lsd_host.frame(16'h0000, 1'b0, got);
    note(d, got);
    note(d, sink_channel);
    // empty latch, then idle edges
    i_lsd_host.strobe();
    i_lsd_host.frame(16'h0000, 1'b0, got);
    i_lsd_host.step(1'b0, 1'b0, 1'b0, got[0]);
    wait_flag(1'b1, 1'b1);
    note(16'h0001, {15'h0000, power_save});
    i_lsd_host.step(1'b1, 1'b0, 1'b0, got[0]);
    i_lsd_host.strobe();
    wait_flag(1'b1, 1'b0);
    note(16'h0001, sink_channel);
    // two detection rounds with random faults
    for (int r = 0; r < 2; r++) begin
      current_low_pin = 16'($urandom);
      voltage_high_pin = 16'($urandom);
      i_lsd_host.mode_seq(`LSD_SEQ_LE_ENTER);
      wait_flag(1'b0, 1'b1);
      note(16'h0001, {15'h0000, detect_mode});
      i_lsd_host.frame(16'hffff, 1'b1, got);
      i_lsd_host.strobe();
      i_lsd_host.enable_for(1'b0, 40);
      note(16'hffff, sink_channel);
      i_lsd_host.enable_for(1'b1, 10);
      i_lsd_host.frame(16'h0000, 1'b1, got);
      note(current_low_pin | voltage_high_pin, got);
      i_lsd_host.mode_seq(`LSD_SEQ_LE_RESUME);
      wait_flag(1'b0, 1'b0);
      note(16'h0000, {15'h0000, detect_mode});
    end
    report_and_stop();
  end
endmodule : testbench
bind lsd_top lsd_top_monitor i_lsd_top_monitor (.ref_clk, .rst, .serial_clk_pin,
  .latch_mode_pin, .enable_mode_pin, .serial_out_pin, .sink_channel, .power_save,
  .detect_mode, .edge_ready);
